/* rtl/sps_params.svh */
// Mode codes, divider reloads and reset values for the serial port
`ifndef SPS_PARAMS_SVH
`define SPS_PARAMS_SVH
// Port mode field codes
`define SPS_MODE_MST_DIV4 4'h0
`define SPS_MODE_MST_DIV16 4'h1
`define SPS_MODE_MST_DIV64 4'h2
`define SPS_MODE_MST_TMR2 4'h3
`define SPS_MODE_SLV_SEL 4'h4
`define SPS_MODE_SLV_NOSEL 4'h5
`define SPS_MODE_I2C_SLV 4'h6
`define SPS_MODE_I2C_FW 4'hb
// Oscillator divide ratios of the master bit rate
`define SPS_RATIO_DIV4 4
`define SPS_RATIO_DIV16 16
`define SPS_RATIO_DIV64 64
// Half-period reload counts, ratio/2 cycles minus one
`define SPS_RELOAD_DIV4 6'((`SPS_RATIO_DIV4 / 2) - 1)
`define SPS_RELOAD_DIV16 6'((`SPS_RATIO_DIV16 / 2) - 1)
`define SPS_RELOAD_DIV64 6'((`SPS_RATIO_DIV64 / 2) - 1)
// Last half period and last bit of a byte; I2C acknowledge and end bit counts
`define SPS_LAST_HALF 4'hf
`define SPS_LAST_BIT 3'h7
`define SPS_I2C_ACK_BIT 4'h8
`define SPS_I2C_END_BIT 4'h9
// Reset values
`define SPS_BUF_RST 8'h00
`endif

/* rtl/sps_pkg.sv */
// Types shared by the serial port design
`default_nettype none
package sps_pkg;
  // Master shifter states
  typedef enum logic {SPS_IDLE, SPS_SHIFT} sps_mst_t;

  // Software control bits
  typedef struct packed {
    logic enable;
    logic [3:0] mode;
    logic cpol;
    logic cke;
    logic sample_phase_bit;
  } sps_cfg_t;

  // Pin direction bits, one means input
  typedef struct packed {
    logic sdo_in;
    logic scl_in;
    logic sda_in;
  } sps_dir_t;

  // Raw pin levels: clock pin, data-in pin, select pin
  typedef struct packed {
    logic sck;
    logic serial_data_in_pin;
    logic ss_b;
  } sps_pin_in_t;

  // Pin drive values and enables
  typedef struct packed {
    logic sck_out;
    logic sck_oe;
    logic sdo_out;
    logic sdo_oe;
    logic sda_out;
    logic sda_oe;
  } sps_pin_out_t;

  // Complete module state
  typedef struct packed {
    sps_pin_in_t s1;
    sps_pin_in_t s2;
    sps_pin_in_t s3;
    sps_pin_in_t filt;
    sps_pin_in_t filt_d;
    sps_mst_t mst;
    logic [5:0] div;
    logic [3:0] half;
    logic rx_bit;
    logic sck;
    logic [2:0] bit_cnt;
    logic [7:0] shreg;
    logic [7:0] buffer;
    logic full;
    logic irq;
    logic wake;
    logic start_det;
    logic stop_det;
    logic [3:0] i_cnt;
    logic i_addr;
    logic i_match;
    logic ack;
    logic hold;
    logic fw_own;
    logic arb;
  } sps_state_t;
endpackage
`default_nettype wire

/* rtl/sps_port.sv */
// Synchronous serial port: SPI master/slave and firmware-assisted I2C
//
// Summary of operation
// - Master transfer starts at once when software writes the transfer buffer.
// - With data output pin an input, master keeps receiving bytes normally.
// - Bytes go most significant bit first.
// - Master clock rate is clock/4, /16, /64 or timer-2 ticks halved.
// - Serial clock idles at the clock polarity bit level.
// - Edge select set puts valid output data before the first clock edge.
// - Sample phase bit picks middle or end of bit for master sampling.
// - Slave shifts on external clock, flags interrupt after last bit latched.
// - Slave keeps working asleep; a received byte raises wake.
// - Select-enabled slave works and drives data out only while select low.
// - Select high floats data output at once, even mid-byte.
// - Select high or port disable resets the port, bit counter to zero.
// - Start and stop flags clear on reset or disable, follow bus events.
// - I2C pins drive only low; direction bits choose release or low.
// - Interrupt flag sets on start and stop in firmware I2C mode, and on each SPI byte or matched I2C slave byte.
// - Firmware master works with slave idle or alongside slave logic.
// - Interrupt enabled during a busy bus fires on the stop.
// - High driven but low sampled on data loses arbitration, lines released except a clock hold.
// - After arbitration loss slave keeps receiving and acknowledges its address.
// - Clock-hold low pulls clock low only once already low; held until set.
`timescale 1ns/10ps
`default_nettype none
`include "sps_params.svh"

module sps_port (
  input wire logic clk,
  input wire logic rst_b,
  input wire sps_pkg::sps_cfg_t cfg,
  input wire logic buf_wr,
  input wire logic [7:0] buf_wdata,
  input wire logic buf_rd,
  input wire logic irq_clear,
  input wire logic timer2_tick,
  input wire logic [6:0] own_address,
  input wire sps_pkg::sps_dir_t dir,
  input wire sps_pkg::sps_pin_in_t pin_in,
  output logic [7:0] transfer_buffer,
  output logic buffer_full,
  output logic serial_port_irq_flag,
  output logic wake_pulse,
  output logic start_detected,
  output logic stop_detected,
  output logic arb_lost,
  output logic busy,
  output var sps_pkg::sps_pin_out_t pin_out
);

  sps_pkg::sps_state_t st;
  sps_pkg::sps_state_t next_st;

  logic master_mode;
  logic slave_mode;
  logic i2c_mode;
  logic slave_sel;
  logic port_reset;
  logic tick;
  logic [5:0] reload;
  logic sck_rise;
  logic sck_fall;
  logic lead;
  logic trail;
  logic samp_edge;
  logic chg_edge;
  logic start_ev;
  logic stop_ev;

  // Mode decode
  assign master_mode = cfg.enable && (cfg.mode == `SPS_MODE_MST_DIV4 ||
                       cfg.mode == `SPS_MODE_MST_DIV16 ||
                       cfg.mode == `SPS_MODE_MST_DIV64 ||
                       cfg.mode == `SPS_MODE_MST_TMR2);
  assign slave_mode = cfg.enable && (cfg.mode == `SPS_MODE_SLV_SEL ||
                      cfg.mode == `SPS_MODE_SLV_NOSEL);
  assign i2c_mode = cfg.enable && (cfg.mode == `SPS_MODE_I2C_SLV ||
                    cfg.mode == `SPS_MODE_I2C_FW);

  assign slave_sel = slave_mode &&
                     (cfg.mode != `SPS_MODE_SLV_SEL || !st.filt.ss_b);
  assign port_reset = !cfg.enable ||
                      (cfg.mode == `SPS_MODE_SLV_SEL && st.filt.ss_b);

  always_comb
  begin
    case (cfg.mode)
      `SPS_MODE_MST_DIV16: reload = `SPS_RELOAD_DIV16;
      `SPS_MODE_MST_DIV64: reload = `SPS_RELOAD_DIV64;
      default: reload = `SPS_RELOAD_DIV4;
    endcase
  end

  // One tick per half period of the serial clock
  assign tick = (cfg.mode == `SPS_MODE_MST_TMR2) ? timer2_tick : (st.div == 6'h00);

  // Edges of the filtered clock pin; filtering costs four cycles of latency
  assign sck_rise = st.filt.sck && !st.filt_d.sck;
  assign sck_fall = !st.filt.sck && st.filt_d.sck;
  assign lead = cfg.cpol ? sck_fall : sck_rise;
  assign trail = cfg.cpol ? sck_rise : sck_fall;
  assign samp_edge = cfg.cke ? lead : trail;
  assign chg_edge = cfg.cke ? trail : lead;

  // Start and stop seen on the bus, data moving while clock high
  assign start_ev = st.filt.sck && st.filt_d.sck && st.filt_d.serial_data_in_pin && !st.filt.serial_data_in_pin;
  assign stop_ev = st.filt.sck && st.filt_d.sck && !st.filt_d.serial_data_in_pin && st.filt.serial_data_in_pin;

  // Next-state logic
  always_comb
  begin
    next_st = st;
    next_st.wake = 1'b0;

    // Pin synchronisers; a change counts once stages two and three agree
    next_st.s1 = pin_in;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.filt_d = st.filt;
    if (st.s2.sck == st.s3.sck)
      next_st.filt.sck = st.s3.sck;
    if (st.s2.serial_data_in_pin == st.s3.serial_data_in_pin)
      next_st.filt.serial_data_in_pin = st.s3.serial_data_in_pin;
    if (st.s2.ss_b == st.s3.ss_b)
      next_st.filt.ss_b = st.s3.ss_b;

    // Software clears; later events override so a set wins
    next_st.irq = st.irq && !irq_clear;
    next_st.full = st.full && !buf_rd;

    // SPI master
    case (st.mst)
      sps_pkg::SPS_IDLE:
      begin
        next_st.half = 4'h0;
        if (master_mode && buf_wr)
        begin
          next_st.mst = sps_pkg::SPS_SHIFT;
          next_st.shreg = buf_wdata;
          next_st.div = reload;
        end
      end
      sps_pkg::SPS_SHIFT:
      begin
        if (!master_mode)
          next_st.mst = sps_pkg::SPS_IDLE;
        else if (tick)
        begin
          next_st.div = reload;
          next_st.half = st.half + 4'h1;
          if (!st.half[0])
            next_st.rx_bit = st.filt.serial_data_in_pin;
          else
          begin
            next_st.shreg = {st.shreg[6:0], cfg.sample_phase_bit ? st.filt.serial_data_in_pin : st.rx_bit};
          end
          if (st.half == `SPS_LAST_HALF)
          begin
            next_st.mst = sps_pkg::SPS_IDLE;
            next_st.buffer = {st.shreg[6:0], cfg.sample_phase_bit ? st.filt.serial_data_in_pin : st.rx_bit};
            next_st.full = 1'b1;
            next_st.irq = 1'b1;
          end
        end
        else
          next_st.div = st.div - 6'h01;
      end
      default: next_st.mst = sps_pkg::SPS_IDLE;
    endcase

    // Clock idle level; active level in odd or even halves
    if (next_st.mst == sps_pkg::SPS_SHIFT)
      next_st.sck = cfg.cpol ^ (cfg.cke ? next_st.half[0] : !next_st.half[0]);
    else
      next_st.sck = cfg.cpol;

    // SPI slave
    if (slave_mode)
    begin
      if (buf_wr && st.bit_cnt == 3'h0)
        next_st.shreg = buf_wdata;
      if (slave_sel && samp_edge)
      begin
        next_st.rx_bit = st.filt.serial_data_in_pin;
        next_st.bit_cnt = st.bit_cnt + 3'h1;
        if (st.bit_cnt == `SPS_LAST_BIT)
        begin
          next_st.shreg = {st.shreg[6:0], st.filt.serial_data_in_pin};
          next_st.buffer = {st.shreg[6:0], st.filt.serial_data_in_pin};
          next_st.full = 1'b1;
          next_st.irq = 1'b1;
          next_st.wake = 1'b1;
        end
      end
      else if (slave_sel && chg_edge && st.bit_cnt != 3'h0)
        next_st.shreg = {st.shreg[6:0], st.rx_bit};
    end

    if (port_reset)
      next_st.bit_cnt = 3'h0;

    // I2C bus monitor and slave receiver
    if (i2c_mode)
    begin
      if (start_ev)
      begin
        next_st.start_det = 1'b1;
        next_st.stop_det = 1'b0;
        next_st.i_cnt = 4'h0;
        next_st.i_addr = 1'b1;
        next_st.i_match = 1'b0;
        next_st.ack = 1'b0;
        if (cfg.mode == `SPS_MODE_I2C_FW)
          next_st.irq = 1'b1;
      end
      else if (stop_ev)
      begin
        next_st.start_det = 1'b0;
        next_st.stop_det = 1'b1;
        next_st.i_cnt = 4'h0;
        next_st.i_match = 1'b0;
        next_st.ack = 1'b0;
        next_st.fw_own = 1'b0;
        next_st.arb = 1'b0;
        if (cfg.mode == `SPS_MODE_I2C_FW)
          next_st.irq = 1'b1;
      end
      else if (sck_rise && st.i_cnt < `SPS_I2C_ACK_BIT)
      begin
        next_st.shreg = {st.shreg[6:0], st.filt.serial_data_in_pin};
        next_st.i_cnt = st.i_cnt + 4'h1;
        if (st.i_cnt == 4'h7 && cfg.mode == `SPS_MODE_I2C_SLV)
        begin
          if (st.i_addr)
            next_st.i_match = (st.shreg[6:0] == own_address);
          if (!st.i_addr && st.i_match)
            next_st.buffer = {st.shreg[6:0], st.filt.serial_data_in_pin};
          if ((st.i_addr && st.shreg[6:0] == own_address) || (!st.i_addr && st.i_match))
          begin
            next_st.full = 1'b1;
            next_st.irq = 1'b1;
          end
        end
      end
      else if (sck_rise && st.i_cnt == `SPS_I2C_ACK_BIT)
        next_st.i_cnt = `SPS_I2C_END_BIT;
      else if (sck_fall && st.i_cnt == `SPS_I2C_ACK_BIT)
      begin
        next_st.ack = st.i_match;
      end
      else if (sck_fall && st.i_cnt == `SPS_I2C_END_BIT)
      begin
        next_st.ack = 1'b0;
        next_st.i_cnt = 4'h0;
        next_st.i_addr = 1'b0;
      end

      // Firmware counts as bus master once it pulls either line
      if (!st.arb && (!dir.sda_in || !dir.scl_in))
        next_st.fw_own = 1'b1;
      // Released data seen low at clock rise
      if (st.fw_own && sck_rise && dir.sda_in && !st.filt.serial_data_in_pin && !st.ack)
      begin
        next_st.arb = 1'b1;
        next_st.fw_own = 1'b0;
      end

      // Hold engages only after clock already low
      next_st.hold = !cfg.cpol && (st.hold || !st.filt.sck);
    end
    else
    begin
      next_st.i_cnt = 4'h0;
      next_st.ack = 1'b0;
      next_st.hold = 1'b0;
      next_st.fw_own = 1'b0;
      next_st.arb = 1'b0;
    end

    if (!cfg.enable)
    begin
      next_st.start_det = 1'b0;
      next_st.stop_det = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      st <= '0;
    else
      st <= next_st;
  end

  // Status outputs straight from state
  assign transfer_buffer = st.buffer;
  assign buffer_full = st.full;
  assign serial_port_irq_flag = st.irq;
  assign wake_pulse = st.wake;
  assign start_detected = st.start_det;
  assign stop_detected = st.stop_det;
  assign arb_lost = st.arb;
  assign busy = (st.mst == sps_pkg::SPS_SHIFT);

  // Pin drive; I2C lines only ever pull low, pull-ups are external
  always_comb
  begin
    pin_out.sck_out = i2c_mode ? 1'b0 : st.sck;
    // Clock pin always driven in master modes; in I2C driven low via direction or clock hold
    pin_out.sck_oe = master_mode ||
                     (i2c_mode && ((!dir.scl_in && !st.arb) || st.hold));
    pin_out.sdo_out = st.shreg[7];
    pin_out.sdo_oe = !dir.sdo_in && (master_mode || slave_sel);
    pin_out.sda_out = 1'b0;
    pin_out.sda_oe = i2c_mode && ((!dir.sda_in && !st.arb) || st.ack);
  end

endmodule

`default_nettype wire

/* tb/sps_port_sva.sv */
// Concurrent checks on the serial port pins and flags
`timescale 1ns/10ps
`default_nettype none
module sps_port_sva (
  input wire logic clk,
  input wire logic rst_b,
  input wire sps_pkg::sps_cfg_t cfg,
  input wire logic buf_wr,
  input wire logic [7:0] buf_wdata,
  input wire sps_pkg::sps_dir_t dir,
  input wire sps_pkg::sps_pin_in_t pin_in,
  input wire logic busy,
  input wire logic start_detected,
  input wire logic stop_detected,
  input wire logic arb_lost,
  input wire logic serial_port_irq_flag,
  input wire sps_pkg::sps_pin_out_t pin_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // A master write that the port must take
  wire logic go = cfg.enable && cfg.mode <= 4'h3 && buf_wr && !busy;
  wire logic wd7 = buf_wdata[7];
  start_xfer_a: assert property (go |=> busy)
    else $error("write not started");
  msb_first_a: assert property (go |=> pin_out.sdo_out == $past(wd7))
    else $error("first bit not msb");
  eight_bits_a: assert property (go && cfg.mode == 4'h0 |-> ##32 busy ##1 !busy)
    else $error("div4 transfer length");
  // Config must settle a cycle before the idle level is judged
  sck_idle_a: assert property (cfg.enable && cfg.mode <= 4'h3 && !busy && !$past(busy)
      && $stable(cfg) |-> pin_out.sck_out == cfg.cpol)
    else $error("clock idle level");
  ss_float_a: assert property ((cfg.enable && cfg.mode == 4'h4 && pin_in.ss_b)[*6]
      |-> !pin_out.sdo_oe)
    else $error("data out driven unselected");
  i2c_low_a: assert property (cfg.enable && (cfg.mode == 4'h6 || cfg.mode == 4'hb)
      && $stable(cfg.mode) |-> !pin_out.sda_out && !pin_out.sck_out)
    else $error("open drain drove high");
  sda_drive_a: assert property (cfg.enable && cfg.mode == 4'hb && !dir.sda_in && !arb_lost
      |-> pin_out.sda_oe)
    else $error("data pin not pulled low");
  arb_release_a: assert property (arb_lost && cfg.mode == 4'hb && cfg.cpol
      |-> !pin_out.sda_oe && !pin_out.sck_oe)
    else $error("lines kept after loss");
  dis_clear_a: assert property (!cfg.enable |=> !start_detected && !stop_detected)
    else $error("flags kept while disabled");
  start_irq_a: assert property (cfg.mode == 4'hb && $rose(start_detected)
      |-> ##[0:1] serial_port_irq_flag)
    else $error("no flag on start");
endmodule
bind sps_port sps_port_sva chk (.clk(clk), .rst_b(rst_b), .cfg(cfg), .buf_wr(buf_wr),
  .buf_wdata(buf_wdata), .dir(dir), .pin_in(pin_in), .busy(busy),
  .start_detected(start_detected), .stop_detected(stop_detected), .arb_lost(arb_lost),
  .serial_port_irq_flag(serial_port_irq_flag), .pin_out(pin_out));
`default_nettype wire

/* tb/sps_spi_peer.sv */
// Behavioural SPI slave facing the port in master modes
`timescale 1ns/10ps
`default_nettype none
module sps_spi_peer (
  input wire logic sel,
  input wire logic sck,
  input wire logic mosi,
  input wire logic cpol,
  input wire logic cke,
  input wire logic [7:0] tx,
  output logic miso,
  output logic [7:0] rx
);
  logic [7:0] sh = 8'h00;
  int n = 0;
  // Unselected line shows the inverse, never a stale bit
  assign miso = sel ? sh[7] : !sh[7];
  // Frame start loads the reply
  always @(posedge sel)
  begin
    sh = tx;
    n = 0;
    rx = 8'h00;
  end
  always @(sck)
  begin
    if (sel && ((sck ^ cpol) == cke))
    begin
      rx = {rx[6:0], mosi};
      n++;
    end
    else if (sel && n != 0)
      sh = {sh[6:0], 1'b0};
  end
endmodule
`default_nettype wire

/* tb/sps_port_tb.sv */
// Self-checking bench for the serial port
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_errors++; \
  $display("unexpected %0t: got %0h want %0h", $time, a, b); end end
module sps_port_tb;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  sps_pkg::sps_cfg_t cfg = '{1'b1, 4'h0, 1'b0, 1'b0, 1'b0};
  sps_pkg::sps_dir_t dir = 3'h7;
  logic buf_wr = 1'b0;
  logic [7:0] buf_wdata = 8'h00;
  logic buf_rd = 1'b0;
  logic irq_clear = 1'b0;
  logic ext_sck = 1'b0;
  logic ext_sdi = 1'b0;
  logic ss_b = 1'b1;
  logic scl = 1'b1;
  logic sda = 1'b1;
  logic sel = 1'b0;
  logic woke = 1'b0;
  logic t2 = 1'b0;
  logic [7:0] tx = 8'h00;
  logic [7:0] rx, tbuf;
  logic miso, i2c, full, irq, wake, st, sp, arb, busy;
  sps_pkg::sps_pin_in_t pin_in;
  sps_pkg::sps_pin_out_t pin_out;
  int n_errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  // Wire levels from every party; I2C lines are pulled up
  assign i2c = cfg.mode == 4'h6 || cfg.mode == 4'hb;
  assign pin_in = {i2c ? scl && !pin_out.sck_oe : (pin_out.sck_oe ? pin_out.sck_out : ext_sck),
    i2c ? sda && !pin_out.sda_oe : (cfg.mode <= 4'h3 ? miso : ext_sdi), ss_b};
  sps_port uut (.clk(clk), .rst_b(rst_b), .cfg(cfg), .buf_wr(buf_wr), .buf_wdata(buf_wdata),
    .buf_rd(buf_rd), .irq_clear(irq_clear), .timer2_tick(t2), .own_address(7'h2a),
    .dir(dir), .pin_in(pin_in), .transfer_buffer(tbuf), .buffer_full(full),
    .serial_port_irq_flag(irq), .wake_pulse(wake), .start_detected(st), .stop_detected(sp),
    .arb_lost(arb), .busy(busy), .pin_out(pin_out));
  // Released data output floats, so the peer sees the inverse of the last bit
  sps_spi_peer peer (.sel(sel), .sck(pin_out.sck_out),
    .mosi(pin_out.sdo_oe ? pin_out.sdo_out : !pin_out.sdo_out),
    .cpol(cfg.cpol), .cke(cfg.cke), .tx(tx), .miso(miso), .rx(rx));
  always #4 clk = !clk;
  // Wake is one cycle wide, so latch it; also cut a hang short
  always @(posedge clk)
  begin
    if (wake)
      woke <= 1'b1;
    // Timer-2 stand-in, a tick every other cycle while shifting
    t2 <= #1 busy && !t2;
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_errors++;
      end_sim();
    end
  end
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic ack_flags();
    buf_rd = 1'b1;
    irq_clear = 1'b1;
    step(1);
    buf_rd = 1'b0;
    irq_clear = 1'b0;
    woke = 1'b0;
  endtask
  // Master byte; write is held into busy to show it is ignored
  task automatic master_xfer(input logic [3:0] mode, input logic pol, input logic ph,
    input int half);
    int n;
    logic [7:0] wr;
    n = 2;
    wr = 8'hb1 ^ {mode, 4'h0};
    cfg = '{1'b1, mode, pol, ph, pol};
    dir.sdo_in = mode == 4'h2;
    tx = 8'h3c ^ {4'h0, mode};
    step(4);
    `CHK(pin_out.sck_out, pol)
    sel = 1'b1;
    buf_wdata = wr;
    buf_wr = 1'b1;
    step(1);
    buf_wdata = 8'h0f;
    step(2);
    buf_wr = 1'b0;
    while (busy && n < 3000)
    begin
      step(1);
      n++;
    end
    `CHK(n, 16 * half)
    `CHK(rx, mode == 4'h2 ? ~wr : wr)
    `CHK({full, irq}, 2'b11)
    if (mode == 4'h1 || mode == 4'h2)
      `CHK(tbuf, tx)
    sel = 1'b0;
    ack_flags();
    `CHK({full, irq}, 2'b00)
    $display("master mode %0h done", mode);
  endtask
  // Slave byte on the bench's clock; cut drops select after four bits
  task automatic slave_byte(input logic [3:0] mode, input logic ph, input logic [7:0] d,
    input logic cut);
    cfg = '{1'b1, mode, 1'b0, ph, 1'b0};
    ss_b = 1'b0;
    step(8);
    `CHK(pin_out.sdo_oe, 1'b1)
    for (int i = 7; i >= 0; i--)
    begin
      ext_sdi = d[i];
      step(6);
      ext_sck = 1'b1;
      step(6);
      ext_sck = 1'b0;
      step(6);
      if (cut && i == 4)
      begin
        ss_b = 1'b1;
        step(8);
        `CHK(pin_out.sdo_oe, 1'b0)
        ss_b = 1'b0;
        step(8);
        i = 8;
        cut = 1'b0;
      end
    end
    step(8);
    `CHK({tbuf, full, irq, woke}, {d, 3'b111})
    ss_b = 1'b1;
    ack_flags();
    $display("slave mode %0h done", mode);
  endtask
  // Firmware master: start, lost arbitration, stop, clock hold, disable
  task automatic i2c_seq();
    cfg = '{1'b1, 4'hb, 1'b1, 1'b0, 1'b0};
    dir = 3'h7;
    step(8);
    ack_flags();
    `CHK({st, sp}, 2'b00)
    dir.sda_in = 1'b0;
    step(8);
    `CHK({st, sp, irq, pin_out.sda_oe}, 4'b1011)
    sda = 1'b0;
    step(2);
    dir.sda_in = 1'b1;
    scl = 1'b0;
    step(6);
    scl = 1'b1;
    step(8);
    `CHK(arb, 1'b1)
    dir = 3'h0;
    step(1);
    `CHK({pin_out.sda_oe, pin_out.sck_oe}, 2'b00)
    dir = 3'h7;
    ack_flags();
    sda = 1'b1;
    step(8);
    `CHK({st, sp, arb, irq}, 4'b0101)
    cfg.cpol = 1'b0;
    step(6);
    `CHK(pin_out.sck_oe, 1'b0)
    scl = 1'b0;
    step(6);
    scl = 1'b1;
    step(6);
    `CHK({pin_out.sck_oe, pin_in.sck}, 2'b10)
    cfg.cpol = 1'b1;
    step(6);
    `CHK({pin_out.sck_oe, pin_in.sck}, 2'b01)
    cfg.enable = 1'b0;
    step(2);
    `CHK({st, sp}, 2'b00)
    $display("firmware master sequence done");
  endtask
  // Address byte to the slave receiver; a match is flagged and acknowledged
  task automatic i2c_addr();
    logic [7:0] a;
    a = 8'h54;
    cfg = '{1'b1, 4'h6, 1'b1, 1'b0, 1'b0};
    step(8);
    ack_flags();
    sda = 1'b0;
    step(8);
    for (int i = 7; i >= 0; i--)
    begin
      scl = 1'b0;
      step(6);
      sda = a[i];
      step(6);
      scl = 1'b1;
      step(6);
    end
    scl = 1'b0;
    step(6);
    sda = 1'b1;
    step(2);
    `CHK({full, irq, pin_out.sda_oe, pin_in.serial_data_in_pin}, 4'b1110)
    scl = 1'b1;
    step(6);
    scl = 1'b0;
    step(8);
    `CHK(pin_out.sda_oe, 1'b0)
    sda = 1'b0;
    step(6);
    scl = 1'b1;
    step(6);
    sda = 1'b1;
    step(8);
    `CHK({st, sp}, 2'b01)
    $display("slave address sequence done");
  endtask
  // Main sequence
  initial
  begin
    step(12);
    rst_b = 1'b1;
    step(4);
    master_xfer(4'h0, 1'b0, 1'b1, 2);
    master_xfer(4'h1, 1'b1, 1'b0, 8);
    master_xfer(4'h2, 1'b0, 1'b0, 32);
    master_xfer(4'h3, 1'b1, 1'b1, 2);
    dir = 3'h3;
    slave_byte(4'h4, 1'b1, 8'h96, 1'b1);
    slave_byte(4'h5, 1'b0, 8'h4d, 1'b0);
    i2c_seq();
    i2c_addr();
    end_sim();
  end
endmodule
`default_nettype wire
